//--- core/sba_arbiter.sv
// What this block does
// - read-only arbiter-select bit shows strap level; high means external arbiter, no grants
// - with timeout enabled, count 16 idle cycles while granted master has not started
// - when that timeout expires, remove the grant from the stalled master
// - refresh off: timed-out master ignored for good once it drops its request
// - refresh on: broken state cleared after every other master served once
// - fairness counter reloads from the field on every new grant
// - counter decrements only after the granted master's next frame start
// - fairness field zero keeps grant until owner drops its request
// - toggling on: grant drops one clock, two clocks after frame start
// - internal requester priority bit, one is high, resets to one
// - masters 1 to 8 priority bits, one is high, reset to zero
// - per-requester arbitration enable, cleared excludes it, resets to one
//
// Added by the designer: the strobed register port.
`timescale 1ns/1ps
`include "sba_defines.svh"

module sba_arbiter #(
	parameter int N_EXT = 8
) (
	// clock and reset
	input  wire logic                   core_clk_in,
	input  wire logic                   reset_in,
	// register port
	input  wire logic [`SBA_ADDR_W-1:0] reg_addr_in,
	input  wire logic [31:0]            reg_wdata_in,
	input  wire logic                   reg_wr_in,
	input  wire logic                   reg_rd_in,
	output logic      [31:0]            reg_rdata_out,
	// strap
	input  wire logic                   arbiter_select_strap_in,
	// internal requester of the bridge
	input  wire logic                   int_req_in,
	output logic                        int_gnt_out,
	// secondary bus pins
	input  wire logic [N_EXT-1:0]       req_l_in,
	output logic      [N_EXT-1:0]       gnt_l_out,
	input  wire logic                   frame_l_in,
	input  wire logic                   irdy_l_in
);

	localparam int NREQ = N_EXT + 1;
	localparam int SW   = N_EXT + 3;

	// configuration registers
	logic [NREQ-1:0]            ena_q;
	logic [NREQ-1:0]            prio_q;
	logic [`SBA_FAIR_W-1:0]     fair_q;
	logic                       bmto_en_q;
	logic                       bmrf_en_q;
	logic                       toggle_en_q;
	logic                       ext_arb_q;
	logic                       strap_done_q;
	logic [2:0]                 strap_cnt_q;
	logic [31:0]                rdata_q;

	// arbitration state
	sba_pkg::sba_state_t        state_q;
	sba_pkg::sba_state_t        state_d;
	logic [NREQ-1:0]            owner_q;
	logic [NREQ-1:0]            owner_d;
	logic [NREQ-1:0]            gnt_q;
	logic [NREQ-1:0]            gnt_d;
	logic [NREQ-1:0]            last_q;
	logic [NREQ-1:0]            to_q;
	logic [NREQ-1:0]            to_d;
	logic [NREQ-1:0]            broken_q;
	logic [NREQ-1:0]            broken_d;
	logic [NREQ-1:0]            served_q;
	logic [NREQ-1:0]            served_d;
	logic [`SBA_FAIR_W-1:0]     fcnt_q;
	logic [`SBA_FAIR_W-1:0]     fcnt_d;
	logic [4:0]                 bm_cnt_q;
	logic [4:0]                 bm_cnt_d;
	logic [1:0]                 xcnt_q;
	logic [1:0]                 xcnt_d;
	logic                       frame_l_d1_q;

	// synchronised pins
	logic [SW-1:0]              pins_s;
	logic [N_EXT-1:0]           req_l_s;
	logic                       frame_l_s;
	logic                       irdy_l_s;
	logic                       strap_s;

	// decode and arbitration wires
	wire                        reg_hit;
	wire                        reg_we;
	wire  [NREQ-1:0]            req_vec;
	wire                        arb_on;
	wire  [NREQ-1:0]            eligible;
	wire  [NREQ-1:0]            hi_req;
	wire  [NREQ-1:0]            cand;
	wire  [NREQ-1:0]            pick;
	wire                        bus_idle;
	wire                        frame_fall;
	wire                        owner_req;
	wire                        owner_ok;
	wire                        others_req;
	wire                        grant_new;
	wire                        bm_expire;
	wire                        wait_drop;
	wire                        fair_release;
	wire                        xfer_drop;
	wire                        hole;
	wire                        all_served;
	wire                        refresh;
	logic [31:0]                rd_val;

	// pins from the bus pass the three-stage filter
	sba_sync #(
		.WIDTH   (SW),
		.RST_VAL ({1'b0, 1'b1, 1'b1, {N_EXT{1'b1}}})
	) u_sync (
		.core_clk_in (core_clk_in),
		.reset_in    (reset_in),
		.async_in    ({arbiter_select_strap_in, irdy_l_in, frame_l_in, req_l_in}),
		.sync_out    (pins_s)
	);

	assign req_l_s   = pins_s[N_EXT-1:0];
	assign frame_l_s = pins_s[N_EXT];
	assign irdy_l_s  = pins_s[N_EXT+1];
	assign strap_s   = pins_s[N_EXT+2];

	// register decode
	assign reg_hit = (reg_addr_in == `SBA_ARB_REG_OFS);
	assign reg_we  = reg_wr_in & reg_hit;

	// read image; reserved bits stay zero
	always_comb begin
		rd_val                                     = '0;
		rd_val[`SBA_ENA_LSB +: NREQ]               = ena_q;
		rd_val[`SBA_EXT_BIT]                       = ext_arb_q;
		rd_val[`SBA_BMTO_EN_BIT]                   = bmto_en_q;
		rd_val[`SBA_BMRF_EN_BIT]                   = bmrf_en_q;
		rd_val[`SBA_FAIR_LSB +: `SBA_FAIR_W]       = fair_q;
		rd_val[`SBA_TOGGLE_BIT]                    = toggle_en_q;
		rd_val[`SBA_PRIO_LSB +: NREQ]              = prio_q;
	end

	// writable fields; the arbiter-select bit ignores writes
	always_ff @(posedge core_clk_in or posedge reset_in) begin
		if (reset_in) begin
			ena_q       <= `SBA_ENA_RST;
			prio_q      <= `SBA_PRIO_RST;
			fair_q      <= `SBA_FAIR_RST;
			bmto_en_q   <= 1'b0;
			bmrf_en_q   <= 1'b0;
			toggle_en_q <= 1'b0;
		end else if (reg_we) begin
			ena_q       <= reg_wdata_in[`SBA_ENA_LSB +: NREQ];
			prio_q      <= reg_wdata_in[`SBA_PRIO_LSB +: NREQ];
			fair_q      <= reg_wdata_in[`SBA_FAIR_LSB +: `SBA_FAIR_W];
			bmto_en_q   <= reg_wdata_in[`SBA_BMTO_EN_BIT];
			bmrf_en_q   <= reg_wdata_in[`SBA_BMRF_EN_BIT];
			toggle_en_q <= reg_wdata_in[`SBA_TOGGLE_BIT];
		end
	end

	// read data stands for exactly the cycle after the strobe
	always_ff @(posedge core_clk_in or posedge reset_in) begin
		if (reset_in) begin
			rdata_q <= '0;
		end else begin
			rdata_q <= (reg_rd_in && reg_hit) ? rd_val : '0;
		end
	end

	assign reg_rdata_out = rdata_q;

	// strap is caught once the filter has settled after reset release
	always_ff @(posedge core_clk_in or posedge reset_in) begin
		if (reset_in) begin
			strap_cnt_q  <= '0;
			strap_done_q <= 1'b0;
			ext_arb_q    <= 1'b0;
		end else if (!strap_done_q) begin
			strap_cnt_q <= strap_cnt_q + 3'h1;
			if (strap_cnt_q == `SBA_STRAP_SETTLE) begin
				strap_done_q <= 1'b1;
				ext_arb_q    <= strap_s;
			end
		end
	end

	// request view: bit 0 is the bridge, bits 1..8 the bus masters
	assign req_vec    = {~req_l_s, int_req_in};
	assign arb_on     = strap_done_q & ~ext_arb_q;
	assign eligible   = req_vec & ena_q & ~(to_q | broken_q) & {NREQ{arb_on}};
	assign hi_req     = eligible & prio_q;
	assign cand       = (|hi_req) ? hi_req : eligible;

	// round robin among the chosen priority level
	sba_rr_pick #(
		.N (NREQ)
	) u_pick (
		.req_in   (cand),
		.last_in  (last_q),
		.pick_out (pick)
	);

	// bus and owner conditions
	assign bus_idle   = frame_l_s & irdy_l_s;
	assign frame_fall = frame_l_d1_q & ~frame_l_s;
	assign owner_req  = |(req_vec & owner_q);
	assign owner_ok   = arb_on & |(owner_q & ena_q);
	assign others_req = |(eligible & ~owner_q);

	// events that start or end a grant
	assign grant_new    = (state_q == sba_pkg::ST_IDLE) && bus_idle && (|eligible);
	assign bm_expire    = (state_q == sba_pkg::ST_WAIT) && bmto_en_q && bus_idle
	                      && !frame_fall
	                      && (bm_cnt_q == `SBA_BM_TIMEOUT_CYC - 5'h1);
	assign wait_drop    = (state_q == sba_pkg::ST_WAIT) && !frame_fall
	                      && (!owner_req || !owner_ok);
	assign fair_release = (state_q == sba_pkg::ST_XFER) && (fair_q != '0)
	                      && others_req && (fcnt_q == '0);
	assign xfer_drop    = (state_q == sba_pkg::ST_XFER) && (!owner_req || !owner_ok);
	assign hole         = (state_q == sba_pkg::ST_XFER) && toggle_en_q
	                      && (xcnt_q == `SBA_TOGGLE_DLY - 2'h1);

	// refresh once all others have had their turn
	assign all_served = &(served_q | ~ena_q | to_q | broken_q | owner_q);
	assign refresh    = bmrf_en_q && all_served && (|(to_q | broken_q));

	// grant sequencing
	always_comb begin
		state_d  = state_q;
		owner_d  = owner_q;
		fcnt_d   = fcnt_q;
		bm_cnt_d = bm_cnt_q;
		xcnt_d   = xcnt_q;
		case (state_q)
			sba_pkg::ST_IDLE: begin
				if (grant_new) begin
					state_d  = sba_pkg::ST_WAIT;
					owner_d  = pick;
					fcnt_d   = fair_q;
					bm_cnt_d = '0;
				end
			end
			sba_pkg::ST_WAIT: begin
				if (frame_fall) begin
					state_d = sba_pkg::ST_XFER;
					xcnt_d  = '0;
				end else if (bm_expire || wait_drop) begin
					state_d = sba_pkg::ST_IDLE;
					owner_d = '0;
				end else if (bmto_en_q && bus_idle) begin
					bm_cnt_d = bm_cnt_q + 5'h1;
				end
			end
			sba_pkg::ST_XFER: begin
				if (xcnt_q != '1) begin
					xcnt_d = xcnt_q + 2'h1;
				end
				if (fair_release || xfer_drop) begin
					state_d = sba_pkg::ST_IDLE;
					owner_d = '0;
				end else if (others_req && (fcnt_q != '0)) begin
					fcnt_d = fcnt_q - 8'h01;
				end
			end
			default: begin
				state_d = sba_pkg::ST_IDLE;
				owner_d = '0;
			end
		endcase
	end

	// grant pins follow the owner except for the toggle hole
	assign gnt_d = owner_d & {NREQ{~hole}};

	// marking, aging and refresh of stalled masters; a new timeout or grant beats refresh, aging into broken does not
	always_comb begin
		to_d     = to_q | (owner_q & {NREQ{bm_expire}});
		broken_d = broken_q | (to_q & ~req_vec);
		served_d = served_q | (pick & {NREQ{grant_new}});
		if (refresh) begin
			to_d     = owner_q & {NREQ{bm_expire}};
			broken_d = '0;
			served_d = pick & {NREQ{grant_new}};
		end
	end

	// state registers
	always_ff @(posedge core_clk_in or posedge reset_in) begin
		if (reset_in) begin
			state_q      <= sba_pkg::ST_IDLE;
			owner_q      <= '0;
			gnt_q        <= '0;
			last_q       <= '0;
			fcnt_q       <= `SBA_FAIR_RST;
			bm_cnt_q     <= '0;
			xcnt_q       <= '0;
			to_q         <= '0;
			broken_q     <= '0;
			served_q     <= '0;
			frame_l_d1_q <= 1'b1;
		end else begin
			state_q      <= state_d;
			owner_q      <= owner_d;
			gnt_q        <= gnt_d;
			last_q       <= grant_new ? pick : last_q;
			fcnt_q       <= fcnt_d;
			bm_cnt_q     <= bm_cnt_d;
			xcnt_q       <= xcnt_d;
			to_q         <= to_d;
			broken_q     <= broken_d;
			served_q     <= served_d;
			frame_l_d1_q <= frame_l_s;
		end
	end

	// grant outputs, straight from flops
	assign int_gnt_out = gnt_q[0];
	assign gnt_l_out   = ~gnt_q[NREQ-1:1];

	// checks
	default clocking cb @(posedge core_clk_in); endclocking
	default disable iff (reset_in);

	property p_ext_no_grant;
		ext_arb_q |-> (gnt_q == '0);
	endproperty
	a_ext_no_grant: assert property (p_ext_no_grant)
		else $error("grant issued while external arbiter selected");

	property p_bm_count;
		(state_q == sba_pkg::ST_WAIT) && bmto_en_q && bus_idle && !frame_fall
		&& !wait_drop && !bm_expire |=> (bm_cnt_q == $past(bm_cnt_q) + 5'h1);
	endproperty
	a_bm_count: assert property (p_bm_count)
		else $error("broken master counter did not advance");

	property p_bm_expire;
		bm_expire |=> (gnt_q == '0) && ((to_q & $past(owner_q)) == $past(owner_q))
		##1 (state_q == sba_pkg::ST_IDLE || (owner_q & $past(owner_q, 2)) == '0);
	endproperty
	a_bm_expire: assert property (p_bm_expire)
		else $error("stalled master kept its grant after timeout");

	property p_broken_out;
		(gnt_q & (broken_q | to_q)) == '0;
	endproperty
	a_broken_out: assert property (p_broken_out)
		else $error("broken master was granted");

	property p_refresh;
		refresh && !bm_expire |=> (broken_q == '0) && (to_q == '0);
	endproperty
	a_refresh: assert property (p_refresh)
		else $error("broken state not refreshed");

	property p_fair_load;
		grant_new |=> (fcnt_q == $past(fair_q)) && (gnt_q == $past(pick));
	endproperty
	a_fair_load: assert property (p_fair_load)
		else $error("fairness counter not reloaded on grant");

	property p_fair_wait;
		(state_q == sba_pkg::ST_WAIT) |=> (fcnt_q == $past(fcnt_q));
	endproperty
	a_fair_wait: assert property (p_fair_wait)
		else $error("fairness counter moved before frame start");

	property p_fair_zero;
		(state_q == sba_pkg::ST_XFER) && (fair_q == '0) && owner_req && owner_ok
		|=> (state_q == sba_pkg::ST_XFER);
	endproperty
	a_fair_zero: assert property (p_fair_zero)
		else $error("grant removed with zero fairness while requested");

	property p_toggle;
		hole && !fair_release && !xfer_drop |=> (gnt_q == '0) ##1 (gnt_q == $past(owner_d));
	endproperty
	a_toggle: assert property (p_toggle)
		else $error("grant toggle not one clock wide");

	property p_prio;
		grant_new && (|hi_req) |-> (|(pick & prio_q)) && ((pick & ~ena_q) == '0);
	endproperty
	a_prio: assert property (p_prio)
		else $error("low priority chosen over pending high priority");

	c_grant:   cover property (grant_new ##1 (state_q == sba_pkg::ST_WAIT) ##[1:20] frame_fall);
	c_expire:  cover property (bm_expire);
	c_toggle:  cover property (hole);
	c_fairrel: cover property (fair_release);

endmodule

//--- core/sba_defines.svh
`ifndef SBA_DEFINES_SVH
`define SBA_DEFINES_SVH

// register map
`define SBA_ADDR_W          8
`define SBA_ARB_REG_OFS     8'h48

// field positions inside the arbiter register
`define SBA_ENA_LSB         0
`define SBA_EXT_BIT         9
`define SBA_BMTO_EN_BIT     10
`define SBA_BMRF_EN_BIT     11
`define SBA_FAIR_LSB        12
`define SBA_FAIR_W          8
`define SBA_TOGGLE_BIT      20
`define SBA_PRIO_LSB        22

// reset values
`define SBA_ENA_RST         9'h1ff
`define SBA_PRIO_RST        9'h001
`define SBA_FAIR_RST        8'h08

// timing counts in bus clocks
`define SBA_BM_TIMEOUT_CYC  5'h10
`define SBA_TOGGLE_DLY      2'h2
`define SBA_STRAP_SETTLE    3'h4

`endif

//--- core/sba_pkg.sv
package sba_pkg;

	// arbiter sequencing states
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_WAIT = 2'b01,
		ST_XFER = 2'b10
	} sba_state_t;

endpackage

//--- core/sba_rr_pick.sv
`timescale 1ns/1ps

module sba_rr_pick #(
	parameter int N = 9
) (
	// candidates and last winner, one-hot
	input  wire logic [N-1:0] req_in,
	input  wire logic [N-1:0] last_in,
	// chosen requester, one-hot, zero when none
	output logic      [N-1:0] pick_out
);

	// search starts just after the last winner and wraps around
	always_comb begin
		int last_idx;
		int idx;
		logic found;
		last_idx = N - 1;
		idx      = 0;
		found    = 1'b0;
		pick_out = '0;
		for (int k = 0; k < N; k++) begin
			if (last_in[k]) begin
				last_idx = k;
			end
		end
		for (int k = 1; k <= N; k++) begin
			idx = (last_idx + k) % N;
			if (!found && req_in[idx]) begin
				pick_out[idx] = 1'b1;
				found         = 1'b1;
			end
		end
	end

endmodule

//--- core/sba_sync.sv
`timescale 1ns/1ps

module sba_sync #(
	parameter int          WIDTH = 1,
	parameter logic [WIDTH-1:0] RST_VAL = '0
) (
	// clock and reset
	input  wire logic             core_clk_in,
	input  wire logic             reset_in,
	// asynchronous levels in, filtered levels out
	input  wire logic [WIDTH-1:0] async_in,
	output logic      [WIDTH-1:0] sync_out
);

	logic [WIDTH-1:0] s1_q;
	logic [WIDTH-1:0] s2_q;
	logic [WIDTH-1:0] s3_q;
	logic [WIDTH-1:0] out_q;
	logic [WIDTH-1:0] out_d;

	// a bit changes only once stage two and three agree
	assign out_d    = (~(s2_q ^ s3_q) & s3_q) | ((s2_q ^ s3_q) & out_q);
	assign sync_out = out_q;

	// three-stage chain; first stage feeds only the second
	always_ff @(posedge core_clk_in or posedge reset_in) begin
		if (reset_in) begin
			s1_q  <= RST_VAL;
			s2_q  <= RST_VAL;
			s3_q  <= RST_VAL;
			out_q <= RST_VAL;
		end else begin
			s1_q  <= async_in;
			s2_q  <= s1_q;
			s3_q  <= s2_q;
			out_q <= out_d;
		end
	end

endmodule

//--- testbench/sba_master_model.sv
`timescale 1ns/1ps

// behavioural requesters: index 0 is the bridge itself, 1..8 the bus masters
module sba_master_model (
	input  wire logic       clk_in,
	input  wire logic [8:0] want_in,
	input  wire logic [8:0] lazy_in,
	input  wire logic [8:0] gnt_in,
	input  wire logic [7:0] burst_in,
	output logic      [8:0] req_out,
	output logic            frame_l_out,
	output logic            irdy_l_out
);
	logic [7:0] cnt_q   = 8'h00;
	logic       busy_q  = 1'b0;
	// power-up: bus released to its pull-up level
	logic       frame_q = 1'b1;
	logic       irdy_q  = 1'b1;

	// requests follow the bench; a lazy master never starts its frame
	assign req_out     = want_in;
	assign frame_l_out = frame_q;
	assign irdy_l_out  = irdy_q;

	// one transaction at a time, started only on grant with the bus idle
	always @(posedge clk_in) begin
		if (busy_q) begin
			cnt_q <= cnt_q - 8'h01;
			if (cnt_q == 8'h01)
				frame_q <= 1'b1;
			if (cnt_q == 8'h00) begin
				irdy_q <= 1'b1;
				busy_q <= 1'b0;
			end
		end else if (frame_q && irdy_q) begin
			for (int k = 0; k < 9; k++) begin
				if (gnt_in[k] && want_in[k] && !lazy_in[k]) begin
					frame_q     <= 1'b0;
					irdy_q      <= 1'b0;
					busy_q      <= 1'b1;
					cnt_q       <= burst_in;
				end
			end
		end
	end
endmodule

//--- testbench/tb.sv
`timescale 1ns/1ps
`include "sba_defines.svh"

`define CHK(got, exp) begin \
	cmp_count++; \
	if ((got) !== (exp)) begin \
		n_errors++; \
		$display("[FAIL] %0t got %0h want %0h", $time, got, exp); \
	end \
end

module tb;
	localparam logic [7:0] OFS = `SBA_ARB_REG_OFS;
	logic        core_clk_in, reset_in, reg_wr_in, reg_rd_in, strap;
	logic [7:0]  reg_addr_in, gnt_l_out, burst;
	logic [31:0] reg_wdata_in, reg_rdata_out, d, v, dflt;
	logic        int_gnt_out, frame_l_in, irdy_l_in;
	logic [8:0]  want, lazy, req;
	wire  [8:0]  gnt_v = {~gnt_l_out, int_gnt_out};
	int          n_errors, cmp_count, c, w, w2;
	integer      seed;

	sba_arbiter #(.N_EXT(8)) sba_arbiter_inst (
		.core_clk_in(core_clk_in), .reset_in(reset_in), .reg_addr_in(reg_addr_in),
		.reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
		.reg_rdata_out(reg_rdata_out), .arbiter_select_strap_in(strap),
		.int_req_in(req[0]), .int_gnt_out(int_gnt_out), .req_l_in(~req[8:1]),
		.gnt_l_out(gnt_l_out), .frame_l_in(frame_l_in), .irdy_l_in(irdy_l_in));

	sba_master_model sba_master_model_inst (
		.clk_in(core_clk_in), .want_in(want), .lazy_in(lazy), .gnt_in(gnt_v),
		.burst_in(burst), .req_out(req), .frame_l_out(frame_l_in),
		.irdy_l_out(irdy_l_in));

	// clock at 100 MHz
	always #5 core_clk_in = ~core_clk_in;

	// expected register word built field by field
	function automatic logic [31:0] mk(logic [8:0] en, logic to, logic rf,
			logic [7:0] fr, logic tg, logic [8:0] pr);
		return {1'b0, pr, 1'b0, tg, fr, rf, to, strap, en};
	endfunction

	task automatic tick(input int n);
		repeat (n) @(posedge core_clk_in);
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] x);
		reg_addr_in  <= a;
		reg_wdata_in <= x;
		reg_wr_in    <= 1'b1;
		@(posedge core_clk_in);
		reg_wr_in <= 1'b0;
	endtask

	// read data is looked at only in the cycle after the strobe
	task automatic rd(input logic [7:0] a, output logic [31:0] x);
		reg_addr_in <= a;
		reg_rd_in   <= 1'b1;
		@(posedge core_clk_in);
		reg_rd_in <= 1'b0;
		@(negedge core_clk_in);
		x = reg_rdata_out;
		@(posedge core_clk_in);
	endtask

	// cycles until requester i shows grant level g, -1 if never within n
	task automatic wait_g(input int i, input logic g, input int n, output int r);
		r = -1;
		for (int j = 0; j < n && r < 0; j++) begin
			@(negedge core_clk_in);
			if (gnt_v[i] === g)
				r = j;
			@(posedge core_clk_in);
		end
	endtask

	// first requester other than p seen granted
	task automatic who(input int p, output int r);
		r = -1;
		for (int j = 0; j < 80 && r < 0; j++) begin
			@(negedge core_clk_in);
			for (int k = 0; k < 9; k++)
				if (gnt_v[k] === 1'b1 && k != p)
					r = k;
			@(posedge core_clk_in);
		end
	endtask

	// cycles out of n in which any requester of mask m is granted
	task automatic cnt(input logic [8:0] m, input int n, output int r);
		r = 0;
		repeat (n) begin
			@(negedge core_clk_in);
			if ((gnt_v & m) !== 9'h000)
				r++;
			@(posedge core_clk_in);
		end
	endtask

	task automatic idle();
		want <= 9'h000;
		tick(50);
	endtask

	// one full transaction of requester i
	task automatic serve(input int i);
		want <= want | (9'h001 << i);
		wait_g(i, 1'b1, 80, c);
		`CHK(c >= 0, 1'b1)
		tick(3);
		want <= want & ~(9'h001 << i);
		wait_g(i, 1'b0, 40, c);
		`CHK(c >= 0, 1'b1)
		tick(14);
	endtask

	task automatic summarize();
		$display("errors %0d compares %0d", n_errors, cmp_count);
		if (n_errors == 0 && cmp_count > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	// never more than one grant at a time
	always @(negedge core_clk_in) begin
		if (!reset_in)
			`CHK($countones(gnt_v) <= 1, 1'b1)
	end

	// watchdog
	initial begin
		tick(30000);
		n_errors++;
		summarize();
	end

	// main sequence
	initial begin
		core_clk_in = 1'b0;
		reset_in = 1'b1;
		{reg_wr_in, reg_rd_in, strap, reg_addr_in, reg_wdata_in} = '0;
		{want, lazy, n_errors, cmp_count} = '0;
		burst = 8'h04;
		seed = 20;
		dflt = mk(9'h1ff, 1'b0, 1'b0, 8'h08, 1'b0, 9'h001);
		tick(10);
		reset_in <= 1'b0;
		tick(8);
		rd(OFS, d);
		`CHK(d, dflt)
		repeat (6) begin
			v = $random(seed);
			wr(OFS, v);
			rd(OFS, d);
			`CHK(d, (v & 32'h7fdffdff) | {22'h0, strap, 9'h0})
		end
		rd(8'h4c, d);
		`CHK(d, 32'h0)
		wr(8'h4c, 32'hffffffff);
		rd(OFS, d);
		`CHK(d, (v & 32'h7fdffdff))
		wr(OFS, dflt);
		for (int i = 0; i < 9; i++) begin
			burst <= 8'h02 + 8'($random(seed) & 32'h7);
			serve(i);
		end
		wr(OFS, mk(9'h000, 1'b0, 1'b0, 8'h08, 1'b0, 9'h020));
		want <= 9'h021;
		tick(8);
		wr(OFS, mk(9'h1ff, 1'b0, 1'b0, 8'h08, 1'b0, 9'h020));
		who(-1, w);
		`CHK(w, 5)
		idle();
		wr(OFS, mk(9'h1ff, 1'b0, 1'b0, 8'h08, 1'b0, 9'h008));
		want <= 9'h00e;
		who(-1, w);
		`CHK(w, 3)
		tick(3);
		want <= 9'h006;
		who(3, w);
		tick(3);
		want <= 9'h006 & ~(9'h001 << w);
		who(w, w2);
		`CHK(w + w2, 3)
		idle();
		wr(OFS, mk(9'h1fb, 1'b0, 1'b0, 8'h08, 1'b0, 9'h001));
		want <= 9'h004;
		cnt(9'h004, 60, c);
		`CHK(c, 0)
		wr(OFS, dflt);
		wait_g(2, 1'b1, 60, c);
		`CHK(c >= 0, 1'b1)
		idle();
		burst <= 8'h14;
		for (int t = 1; t >= 0; t--) begin
			wr(OFS, mk(9'h1ff, 1'b0, 1'b0, 8'h08, t[0], 9'h001));
			want <= 9'h010;
			wait_g(4, 1'b1, 60, c);
			cnt(9'h010, 14, c);
			`CHK(c, 14 - t)
			idle();
		end
		burst <= 8'h28;
		for (int f = 0; f <= 4; f += 4) begin
			wr(OFS, mk(9'h1ff, 1'b0, 1'b0, f[7:0], 1'b0, 9'h001));
			want <= 9'h002;
			wait_g(1, 1'b1, 60, c);
			tick(4);
			want <= 9'h006;
			wait_g(1, 1'b0, 60, c);
			if (f == 0)
				`CHK(c, -1)
			else
				`CHK(c >= 4 && c <= 20, 1'b1)
			want <= 9'h004;
			wait_g(2, 1'b1, 90, c);
			`CHK(c >= 0, 1'b1)
			idle();
		end
		lazy <= 9'h0c0;
		want <= 9'h040;
		wait_g(6, 1'b1, 60, c);
		wait_g(6, 1'b0, 40, c);
		`CHK(c, -1)
		wr(OFS, mk(9'h1ff, 1'b1, 1'b0, 8'h08, 1'b0, 9'h001));
		wait_g(6, 1'b1, 60, c);
		wait_g(6, 1'b0, 40, c);
		`CHK(c >= 15 && c <= 18, 1'b1)
		want <= 9'h000;
		tick(6);
		want <= 9'h040;
		cnt(9'h040, 60, c);
		`CHK(c, 0)
		idle();
		wr(OFS, mk(9'h1bf, 1'b1, 1'b1, 8'h08, 1'b0, 9'h001));
		want <= 9'h080;
		wait_g(7, 1'b1, 60, c);
		wait_g(7, 1'b0, 40, c);
		want <= 9'h000;
		tick(6);
		want <= 9'h080;
		cnt(9'h080, 30, c);
		`CHK(c, 0)
		want <= 9'h000;
		lazy <= 9'h000;
		tick(6);
		for (int i = 0; i < 6; i++)
			serve(i);
		serve(8);
		want <= 9'h080;
		wait_g(7, 1'b1, 80, c);
		`CHK(c >= 0, 1'b1)
		idle();
		strap <= 1'b1;
		reset_in <= 1'b1;
		tick(3);
		reset_in <= 1'b0;
		tick(8);
		rd(OFS, d);
		`CHK(d[9], 1'b1)
		want <= 9'h003;
		cnt(9'h1ff, 60, c);
		`CHK(c, 0)
		summarize();
	end
endmodule
